// ==== hdl/emct_regs.sv ====
// Purpose: extended mode and output control registers behind the management pins
// Assumes: mdc and mdio inputs synchronous to ref_clk; strap pins stable at reset
// Notes:   only addresses 0x13 and 0x14 (0x14 not in legacy bank 1) are answered; others leave mdio undriven
`timescale 1ns/100ps
`default_nettype none
module emct_regs
   import emct_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   input  wire logic [4:0] phy_addr,
   input  wire logic       strap_repeater,
   input  wire logic       strap_hw_speed,
   input  wire logic       speed_pin,
   input  wire logic       reg0_speed_sel,
   input  wire logic       remote_fault,
   input  wire logic       mdc,
   input  wire logic       mdio_in,
   output var  emct_pin_t  mdio_pin,
   output var  emct_ctrl_t ctrl,
   output var  logic [15:0] output_reg
);
   logic        mdc_level;
   logic        mdc_rise;
   emct_state_t state;
   emct_state_t next_state;
   logic [5:0]  cnt;
   logic [5:0]  next_cnt;
   logic [12:0] hdr;
   logic [12:0] next_hdr;
   logic [15:0] shreg;
   logic [15:0] next_shreg;
   logic [4:0]  reg_sel;
   logic [4:0]  next_reg_sel;
   emct_pin_t   next_mdio_pin;
   logic        wr_go;
   logic        bit_in;
   logic [15:0] mode_reg;
   logic [15:0] next_mode_reg;
   logic [15:0] next_output_reg;
   logic        strap_taken;
   logic        next_strap_taken;
   logic [15:0] rd_mux;
   logic        hit;
   emct_ctrl_t  next_ctrl;

   emct_pin_edge u_mdc (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .pin     (mdc),
      .level   (mdc_level),
      .rise    (mdc_rise)
   );

   // mdio registered with mdc so both describe the same instant
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bit_in <= 1'b0;
      end else begin
         bit_in <= mdio_in;
      end
   end

   // bank 1 swaps in the legacy set above 0x13, so 0x14 is not ours there
   always_comb begin
      hit    = 1'b0;
      rd_mux = 16'h0000;
      if (reg_sel == EMCT_OFS_MODE) begin
         hit    = 1'b1;
         rd_mux = mode_reg;
         rd_mux[EMCT_BIT_REM_FAULT] = remote_fault;
      end else if (reg_sel == EMCT_OFS_OUTPUT &&
                   mode_reg[EMCT_BANK_HI:EMCT_BANK_LO] != EMCT_BANK_LEGACY) begin
         hit    = 1'b1;
         rd_mux = output_reg;
      end
   end

   always_comb begin
      next_state    = state;
      next_cnt      = cnt;
      next_hdr      = hdr;
      next_shreg    = shreg;
      next_reg_sel  = reg_sel;
      next_mdio_pin = mdio_pin;
      wr_go         = 1'b0;
      if (mdc_rise) begin
         case (state)
            EMCT_PRE: begin
               if (bit_in) begin
                  if (cnt != EMCT_PREAMBLE_LEN) begin
                     next_cnt = cnt + 6'h01;
                  end
               end else if (cnt == EMCT_PREAMBLE_LEN) begin
                  next_state = EMCT_HDR;
                  next_cnt   = 6'h00;
               end else begin
                  next_cnt = 6'h00;
               end
            end
            EMCT_HDR: begin
               next_hdr = {hdr[11:0], bit_in};
               next_cnt = cnt + 6'h01;
               if (cnt == EMCT_HDR_LAST) begin
                  next_cnt     = 6'h00;
                  next_reg_sel = next_hdr[4:0];
                  next_state   = EMCT_PRE;
                  if (next_hdr[12] && next_hdr[9:5] == phy_addr) begin
                     if (next_hdr[11:10] == EMCT_OP_READ) begin
                        next_state = EMCT_TA_RD;
                     end else if (next_hdr[11:10] == EMCT_OP_WRITE) begin
                        next_state = EMCT_TA_WR;
                     end
                  end
               end
            end
            EMCT_TA_RD: begin
               next_state = EMCT_PRE;
               if (hit) begin
                  next_mdio_pin.mdio_oe  = 1'b1;
                  next_mdio_pin.mdio_out = 1'b0;
                  next_shreg = rd_mux;
                  next_state = EMCT_RDATA;
               end
            end
            EMCT_RDATA: begin
               next_mdio_pin.mdio_out = shreg[15];
               next_shreg = {shreg[14:0], 1'b0};
               next_cnt   = cnt + 6'h01;
               if (cnt == EMCT_DATA_LAST + 6'h01) begin
                  next_mdio_pin.mdio_oe  = 1'b0;
                  next_mdio_pin.mdio_out = 1'b0;
                  next_cnt   = 6'h00;
                  next_state = EMCT_PRE;
               end
            end
            EMCT_TA_WR: begin
               next_cnt = cnt + 6'h01;
               if (cnt == EMCT_TA_LAST) begin
                  next_cnt   = 6'h00;
                  next_state = EMCT_WDATA;
               end
            end
            EMCT_WDATA: begin
               next_shreg = {shreg[14:0], bit_in};
               next_cnt   = cnt + 6'h01;
               if (cnt == EMCT_DATA_LAST) begin
                  wr_go      = 1'b1;
                  next_cnt   = 6'h00;
                  next_state = EMCT_PRE;
               end
            end
            default: begin
               next_state = EMCT_PRE;
               next_cnt   = 6'h00;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state    <= EMCT_PRE;
         cnt      <= 6'h00;
         hdr      <= 13'h0000;
         shreg    <= 16'h0000;
         reg_sel  <= 5'h00;
         mdio_pin <= '0;
      end else begin
         state    <= next_state;
         cnt      <= next_cnt;
         hdr      <= next_hdr;
         shreg    <= next_shreg;
         reg_sel  <= next_reg_sel;
         mdio_pin <= next_mdio_pin;
      end
   end

   // straps are caught on the first edge after reset release
   always_comb begin
      next_mode_reg    = mode_reg;
      next_output_reg  = output_reg;
      next_strap_taken = 1'b1;
      if (!strap_taken) begin
         next_mode_reg[EMCT_BIT_REPEATER] = strap_repeater;
         next_mode_reg[EMCT_BIT_HW_SPEED] = strap_hw_speed;
      end
      if (wr_go && hit) begin
         if (reg_sel == EMCT_OFS_MODE) begin
            // read-only bits keep their value
            next_mode_reg = (mode_reg & ~EMCT_MODE_WMASK) | (next_shreg & EMCT_MODE_WMASK);
         end else begin
            next_output_reg = next_shreg;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_reg    <= EMCT_MODE_RESET;
         output_reg  <= EMCT_OUTPUT_RESET;
         strap_taken <= 1'b0;
      end else begin
         mode_reg    <= next_mode_reg;
         output_reg  <= next_output_reg;
         strap_taken <= next_strap_taken;
      end
   end

   always_comb begin
      next_ctrl.repeater_req = mode_reg[EMCT_BIT_REPEATER];
      next_ctrl.speed_100    = mode_reg[EMCT_BIT_HW_SPEED] ? speed_pin
                                                           : reg0_speed_sel;
      next_ctrl.bank_sel     = mode_reg[EMCT_BANK_HI:EMCT_BANK_LO];
      next_ctrl.auto_crossover_enable   = mode_reg[EMCT_BIT_AUTO_XO];
      next_ctrl.manual_crossover_select = mode_reg[EMCT_BIT_MAN_XO];
      next_ctrl.pair_output_tristate    = mode_reg[EMCT_BIT_TRISTATE];
      next_ctrl.auto_pd_100_enable      = mode_reg[EMCT_BIT_AUTO_PD];
      next_ctrl.drive_strength_high     = output_reg[EMCT_BIT_STRENGTH];
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= '0;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // the release edge still clears ctrl, so attempts starting there are skipped
   a_speed_hw_pin: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!sys_rst && mode_reg[EMCT_BIT_HW_SPEED]) |=> ctrl.speed_100 == $past(speed_pin))
      else $error("speed does not follow pin in hardware mode");
   a_speed_sw_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!sys_rst && !mode_reg[EMCT_BIT_HW_SPEED]) |=> ctrl.speed_100 == $past(reg0_speed_sel))
      else $error("speed does not follow register bit in software mode");
   a_bank_legacy: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (mode_reg[EMCT_BANK_HI:EMCT_BANK_LO] == EMCT_BANK_LEGACY && reg_sel == EMCT_OFS_OUTPUT)
      |-> !hit)
      else $error("output register answered in legacy bank");
   a_legacy_nowrite: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (wr_go && reg_sel == EMCT_OFS_OUTPUT &&
       mode_reg[EMCT_BANK_HI:EMCT_BANK_LO] == EMCT_BANK_LEGACY) |=> $stable(output_reg))
      else $error("output register written in legacy bank");
   a_xover_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (wr_go && reg_sel == EMCT_OFS_MODE) |=> ##1
      ctrl.auto_crossover_enable == $past(next_shreg[EMCT_BIT_AUTO_XO], 2))
      else $error("crossover enable not updated by write");
   a_tristate_out: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(mode_reg[EMCT_BIT_TRISTATE]) |=> ctrl.pair_output_tristate)
      else $error("tristate control not forwarded");
   a_autopd_out: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $fell(mode_reg[EMCT_BIT_AUTO_PD]) |=> !ctrl.auto_pd_100_enable)
      else $error("auto power-down not withdrawn");
   a_strength_out: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (wr_go && hit && reg_sel == EMCT_OFS_OUTPUT) |=> ##1
      ctrl.drive_strength_high == $past(next_shreg[EMCT_BIT_STRENGTH], 2))
      else $error("drive strength not updated by write");
   a_ro_kept: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (wr_go && reg_sel == EMCT_OFS_MODE) |=> mode_reg[10] == $past(mode_reg[10]))
      else $error("read-only bit changed by write");
endmodule : emct_regs
`default_nettype wire

// ==== shared/emct_pkg.sv ====
// Purpose: constants and types for the extended mode control register block
// Assumes: 16-bit management registers reached over the serial management pins
// Notes:   offsets, positions and reset values live here, except read-only mode bit 10, which emct_regs checks by its number
package emct_pkg;
   localparam logic [4:0]  EMCT_OFS_MODE      = 5'h13;
   localparam logic [4:0]  EMCT_OFS_OUTPUT    = 5'h14;
   localparam int          EMCT_BIT_REPEATER  = 15;
   localparam int          EMCT_BIT_HW_SPEED  = 14;
   localparam int          EMCT_BIT_REM_FAULT = 13;
   localparam int          EMCT_BANK_HI       = 12;
   localparam int          EMCT_BANK_LO       = 11;
   localparam int          EMCT_BIT_AUTO_XO   = 9;
   localparam int          EMCT_BIT_MAN_XO    = 8;
   localparam int          EMCT_BIT_TRISTATE  = 7;
   localparam int          EMCT_BIT_AUTO_PD   = 0;
   localparam int          EMCT_BIT_STRENGTH  = 15;
   localparam logic [1:0]  EMCT_BANK_LEGACY   = 2'h1;
   localparam logic [15:0] EMCT_MODE_RESET    = 16'h0201;
   localparam logic [15:0] EMCT_MODE_WMASK    = 16'hDBFF;
   localparam logic [15:0] EMCT_OUTPUT_RESET  = 16'h3FE9;
   localparam logic [5:0]  EMCT_PREAMBLE_LEN  = 6'h20;
   localparam logic [5:0]  EMCT_HDR_LAST      = 6'h0C;
   localparam logic [5:0]  EMCT_TA_LAST       = 6'h01;
   localparam logic [5:0]  EMCT_DATA_LAST     = 6'h0F;
   localparam logic [1:0]  EMCT_OP_READ       = 2'h2;
   localparam logic [1:0]  EMCT_OP_WRITE      = 2'h1;

   typedef enum logic [2:0] {
      EMCT_PRE, EMCT_HDR, EMCT_TA_RD, EMCT_RDATA, EMCT_TA_WR, EMCT_WDATA
   } emct_state_t;

   typedef struct packed {
      logic       repeater_req;
      logic       speed_100;
      logic [1:0] bank_sel;
      logic       auto_crossover_enable;
      logic       manual_crossover_select;
      logic       pair_output_tristate;
      logic       auto_pd_100_enable;
      logic       drive_strength_high;
   } emct_ctrl_t;

   typedef struct packed {
      logic mdio_out;
      logic mdio_oe;
   } emct_pin_t;
endpackage : emct_pkg

// ==== hdl/emct_pin_edge.sv ====
// Purpose: registers a synchronous pin and flags its rising edge
// Assumes: pin already synchronous to ref_clk
// Notes:   rise is a one-cycle pulse aligned with the registered level
`timescale 1ns/100ps
`default_nettype none
module emct_pin_edge (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic pin,
   output var  logic level,
   output var  logic rise
);
   logic next_level;
   logic next_rise;

   always_comb begin
      next_level = pin;
      next_rise  = pin & ~level;
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         level <= 1'b0;
         rise  <= 1'b0;
      end else begin
         level <= next_level;
         rise  <= next_rise;
      end
   end
endmodule : emct_pin_edge
`default_nettype wire

// ==== test/emct_sta.sv ====
// Purpose: station management model that frames reads and writes on mdc/mdio
// Assumes: mdio wire resolved by the bench with a pull-up when nobody drives
// Notes:   mdc stands still low between frames; 4 ref_clk low and 5 ref_clk high per bit
`timescale 1ns/100ps
`default_nettype none
module emct_sta
   import emct_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic mdio_wire,
   output var  logic mdc,
   output var  logic sta_oe,
   output var  logic sta_d
);
   initial begin
      mdc = 1'b0;
      sta_oe = 1'b0;
      sta_d = 1'b1;
   end

   // s is the wire level seen at the mdc rise of this bit
   task automatic bit_cyc(input logic en, input logic b, output logic s);
      @(posedge ref_clk);
      mdc <= 1'b0;
      sta_oe <= en;
      sta_d <= b;
      repeat (4) @(posedge ref_clk);
      s = mdio_wire;
      mdc <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask : bit_cyc

   // st is the start field; anything but 01 must be refused by the device
   task automatic frame(input logic [1:0] st, input logic [1:0] op, input logic [4:0] pa,
                        input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd,
                        output logic ta);
      logic [45:0] hdr;
      logic [17:0] wbits;
      logic        s;
      int          i;
      hdr = {32'hFFFFFFFF, st, op, pa, ra};
      wbits = {2'b10, wd};
      rd = 16'h0000;
      ta = 1'b1;
      for (i = 45; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
      if (op == EMCT_OP_WRITE) begin
         for (i = 17; i >= 0; i--) bit_cyc(1'b1, wbits[i], s);
      end else begin
         // released: both turnaround bits then data D15..D0
         for (i = 0; i < 18; i++) begin
            bit_cyc(1'b0, 1'b1, s);
            if (i == 1) ta = s;
            if (i > 1) rd[17-i] = s;
         end
      end
      @(posedge ref_clk);
      mdc <= 1'b0;
      sta_oe <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask : frame
endmodule : emct_sta
`default_nettype wire

// ==== test/tb.sv ====
// Purpose: self-checking bench for the extended mode and output control registers
// Assumes: management frames from emct_sta, integer model of both registers
// Notes:   refused accesses read back as all ones through the pull-up
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
   import emct_pkg::*;
   logic        ref_clk, sys_rst, strap_repeater, strap_hw_speed, speed_pin;
   logic        reg0_speed_sel, remote_fault, mdc, sta_oe, sta_d, mdio_wire, ta_q;
   logic [4:0]  phy_addr;
   logic [15:0] output_reg, mode_m, out_m, rd_q;
   emct_pin_t   mdio_pin;
   emct_ctrl_t  ctrl;
   int          err_count, checked, i, k;

   assign mdio_wire = mdio_pin.mdio_oe ? mdio_pin.mdio_out : (sta_oe ? sta_d : 1'b1);

   emct_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .phy_addr(phy_addr),
      .strap_repeater(strap_repeater), .strap_hw_speed(strap_hw_speed),
      .speed_pin(speed_pin), .reg0_speed_sel(reg0_speed_sel), .remote_fault(remote_fault),
      .mdc(mdc), .mdio_in(mdio_wire), .mdio_pin(mdio_pin), .ctrl(ctrl),
      .output_reg(output_reg));
   emct_sta sta (.ref_clk(ref_clk), .mdio_wire(mdio_wire), .mdc(mdc), .sta_oe(sta_oe),
      .sta_d(sta_d));

   always #5 ref_clk = ~ref_clk;

   function automatic emct_ctrl_t exp_ctrl();
      return {mode_m[15], mode_m[14] ? speed_pin : reg0_speed_sel, mode_m[12:11],
              mode_m[9], mode_m[8], mode_m[7], mode_m[0], out_m[15]};
   endfunction : exp_ctrl

   task automatic check_all();
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK(ctrl, exp_ctrl())
      `CHK(output_reg, out_m)
   endtask : check_all

   task automatic wr(input logic [4:0] ra, input logic [15:0] d, input logic pa_ok);
      logic [15:0] rd;
      logic        ta;
      sta.frame(2'b01, EMCT_OP_WRITE, pa_ok ? phy_addr : phy_addr ^ 5'h01, ra, d, rd, ta);
      if (pa_ok && ra == EMCT_OFS_MODE) mode_m = d & EMCT_MODE_WMASK;
      if (pa_ok && ra == EMCT_OFS_OUTPUT && mode_m[12:11] != EMCT_BANK_LEGACY) out_m = d;
      check_all();
   endtask : wr

   task automatic rd_exp(input logic [4:0] ra, input logic pa_ok, input logic [1:0] op);
      logic [15:0] rd, exp;
      logic        ta, hit;
      sta.frame(2'b01, op, pa_ok ? phy_addr : phy_addr ^ 5'h01, ra, 16'h0000, rd, ta);
      hit = pa_ok && op == EMCT_OP_READ && (ra == EMCT_OFS_MODE ||
            (ra == EMCT_OFS_OUTPUT && mode_m[12:11] != EMCT_BANK_LEGACY));
      exp = !hit ? 16'hFFFF : ra == EMCT_OFS_MODE ? mode_m | {2'b00, remote_fault, 13'h0000}
            : out_m;
      `CHK(rd, exp)
      `CHK(ta, !hit)
   endtask : rd_exp

   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results

   initial begin
      repeat (80000) @(posedge ref_clk);
      err_count++;
      results();
   end

   initial begin
      ref_clk = 1'b0;
      sys_rst = 1'b1;
      {strap_repeater, strap_hw_speed, speed_pin, reg0_speed_sel, remote_fault} = 5'h00;
      phy_addr = 5'h00;
      err_count = 0;
      checked = 0;
      void'($urandom(32'h1f4d));
      @(posedge ref_clk);
      phy_addr <= 5'($urandom);
      strap_repeater <= 1'($urandom);
      strap_hw_speed <= 1'($urandom);
      repeat (19) @(posedge ref_clk);
      sys_rst <= 1'b0;
      mode_m = EMCT_MODE_RESET | {strap_repeater, strap_hw_speed, 14'h0000};
      out_m = EMCT_OUTPUT_RESET;
      check_all();
      rd_exp(EMCT_OFS_MODE, 1'b1, EMCT_OP_READ);
      rd_exp(EMCT_OFS_OUTPUT, 1'b1, EMCT_OP_READ);
      // every bank code; reserved bits kept at reset values, repeater kept clear
      for (i = 0; i < 4; i++) begin
         wr(EMCT_OFS_MODE, (16'($urandom) & 16'h4381) | 16'(i << 11), 1'b1);
         wr(EMCT_OFS_OUTPUT, 16'h3FC0 | (16'($urandom) & 16'h803F), 1'b1);
         rd_exp(EMCT_OFS_OUTPUT, 1'b1, EMCT_OP_READ);
      end
      for (i = 0; i < 6; i++) begin
         @(posedge ref_clk);
         {speed_pin, reg0_speed_sel, remote_fault} <= 3'($urandom);
         wr(EMCT_OFS_MODE, 16'($urandom) & 16'h5B81, 1'b1);
         rd_exp(EMCT_OFS_MODE, 1'b1, EMCT_OP_READ);
         @(posedge ref_clk);
         {speed_pin, reg0_speed_sel} <= ~{speed_pin, reg0_speed_sel};
         check_all();
      end
      // refused: foreign address, unmapped register, illegal op codes
      wr(EMCT_OFS_MODE, 16'h0000, 1'b0);
      rd_exp(EMCT_OFS_MODE, 1'b0, EMCT_OP_READ);
      rd_exp(5'h15, 1'b1, EMCT_OP_READ);
      for (k = 0; k < 4; k += 3) rd_exp(EMCT_OFS_MODE, 1'b1, 2'(k));
      // start field 00 refused for reads and writes alike
      sta.frame(2'b00, EMCT_OP_READ, phy_addr, EMCT_OFS_MODE, 16'h0000, rd_q, ta_q);
      `CHK(rd_q, 16'hFFFF)
      `CHK(ta_q, 1'b1)
      sta.frame(2'b00, EMCT_OP_WRITE, phy_addr, EMCT_OFS_MODE, ~mode_m & 16'h5B81, rd_q, ta_q);
      check_all();
      // mid-run reset with a flipped speed strap
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      strap_hw_speed <= ~strap_hw_speed;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      mode_m = EMCT_MODE_RESET | {strap_repeater, strap_hw_speed, 14'h0000};
      out_m = EMCT_OUTPUT_RESET;
      check_all();
      rd_exp(EMCT_OFS_OUTPUT, 1'b1, EMCT_OP_READ);
      rd_exp(EMCT_OFS_MODE, 1'b1, EMCT_OP_READ);
      results();
   end
endmodule : tb
`default_nettype wire
